// file: verilog/digital_io_status.sv
`timescale 1ns/100ps
`include "dio_status_consts.svh"
// Behaviour
// - Input function: monitor, interlock, output control
// - Input polarity 0 high-active, 1 low-active
// - Output state reads actual pin level
// - Output source selected by eight function codes
// - Polarity inverts non-static output functions
// - Static codes ignore polarity setting
// - Cleared panel enable locks out panel
// - Only host write or reset restores panel
// - Aux limits raise temperature conditions when enabled
// - Aux limit turns output off if masked
// - Condition mask gates status summary, resets zero
// - Event mask gates status summary, resets zero
// - Host reads back function and polarity
// - Input state reads synchronised pin level
// - Reading event latch returns then clears
// - Output-off mask selects conditions forcing off
module digital_io_status #(
  parameter int NUM_IN = 4,
  parameter int NUM_OUT = 4,
  parameter int IDX_W = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Host command port
  input wire dio_status_pkg::cmd_type cmdOp,
  input wire logic [IDX_W-1:0] cmdPort,
  input wire logic [2:0] cmdFunc,
  input wire logic cmdInvert,
  input wire logic [15:0] cmdData,
  input wire logic [IDX_W-1:0] queryPort,
  input wire logic readEventLatch,
  // Query answers
  output logic [1:0] queryInFunc,
  output logic queryInInvert,
  output logic [2:0] queryOutFunc,
  output logic queryOutInvert,
  output logic queryInPinState,
  output logic queryOutPinState,
  output logic [15:0] eventLatch,
  // Configuration readback
  output logic frontPanelEnable,
  output logic auxLimitEnable,
  output logic [15:0] conditionReportMask,
  output logic [15:0] eventReportMask,
  output logic [15:0] outputOffMask,
  // Pins
  input wire logic [NUM_IN-1:0] inPin,
  output logic [NUM_OUT-1:0] outPin,
  // Instrument state
  input wire logic [15:0] conditionIn,
  input wire logic [15:0] eventIn,
  input wire logic outputOnState,
  input wire logic tempStable,
  input wire logic tempLimit,
  input wire logic currentLimit,
  input wire logic remoteMode,
  input wire logic voltageLimit,
  input wire logic auxAboveHigh,
  input wire logic auxBelowLow,
  input wire logic [NUM_IN-1:0] panelKeys,
  // Derived controls
  output logic panelLocked,
  output logic [NUM_IN-1:0] panelKeysGated,
  output logic [15:0] conditions,
  output logic forceOff,
  output logic outputOnRequest,
  output logic outputOnRequestValid,
  output logic statusSummary
);

  // ----------------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------------
  logic [1:0] inFunc [NUM_IN]; // Per-input function
  logic [NUM_IN-1:0] inInvert; // Per-input polarity
  logic [2:0] outFunc [NUM_OUT]; // Per-output function
  logic [NUM_OUT-1:0] outInvert; // Per-output polarity
  logic [1:0] next_inFunc [NUM_IN];
  logic [NUM_IN-1:0] next_inInvert;
  logic [2:0] next_outFunc [NUM_OUT];
  logic [NUM_OUT-1:0] next_outInvert;
  logic next_frontPanelEnable;
  logic next_auxLimitEnable;
  logic [15:0] next_conditionReportMask;
  logic [15:0] next_eventReportMask;
  logic [15:0] next_outputOffMask;
  logic [15:0] next_eventLatch;
  logic [NUM_OUT-1:0] next_outPin;
  logic [NUM_IN-1:0] inSync; // Synchronised input pins
  logic [NUM_IN-1:0] inActive; // Function asserted per input
  logic [NUM_OUT-1:0] srcActive; // Source state per output
  logic [NUM_IN-1:0] interlockHit;
  logic [NUM_IN-1:0] onCtlHit;
  logic [NUM_IN-1:0] onCtlSel;

  // Pins come from outside, so two flops before use
  port_sync #(.WIDTH(NUM_IN)) port_sync_i (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async(inPin),
    .synced(inSync)
  );

  // ----------------------------------------------------------------------
  // Per-input decode and per-output source select
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      assign inActive[gi] = inSync[gi] ^ inInvert[gi];
      assign interlockHit[gi] = inActive[gi] &&
        (inFunc[gi] == `IN_FUNC_INTERLOCK);
      assign onCtlSel[gi] = (inFunc[gi] == `IN_FUNC_OUTPUT_ON);
      assign onCtlHit[gi] = onCtlSel[gi] && inActive[gi];
    end
    for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
      always_comb begin
        unique case (outFunc[gi])
          `OUT_FUNC_LOW: srcActive[gi] = 1'b0;
          `OUT_FUNC_HIGH: srcActive[gi] = 1'b1;
          `OUT_FUNC_OUTPUT_ON: srcActive[gi] = outputOnState;
          `OUT_FUNC_TEMP_STABLE: srcActive[gi] = tempStable;
          `OUT_FUNC_TEMP_LIMIT: srcActive[gi] = tempLimit;
          `OUT_FUNC_CURR_LIMIT: srcActive[gi] = currentLimit;
          `OUT_FUNC_REMOTE: srcActive[gi] = remoteMode;
          `OUT_FUNC_VOLT_LIMIT: srcActive[gi] = voltageLimit;
        endcase
      end
      always_comb begin
        // Static levels bypass polarity; others may invert
        if (outFunc[gi] == `OUT_FUNC_LOW ||
            outFunc[gi] == `OUT_FUNC_HIGH) begin
          next_outPin[gi] = srcActive[gi];
        end else begin
          next_outPin[gi] = srcActive[gi] ^ outInvert[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Conditions, shutdown and summary
  // ----------------------------------------------------------------------
  always_comb begin
    conditions = conditionIn;
    if (auxLimitEnable) begin
      // Aux sensor adds to the limit bits only while enabled
      conditions[`COND_TEMP_HIGH_BIT] =
        conditionIn[`COND_TEMP_HIGH_BIT] | auxAboveHigh;
      conditions[`COND_TEMP_LOW_BIT] =
        conditionIn[`COND_TEMP_LOW_BIT] | auxBelowLow;
    end
  end

  // Interlock or masked condition stops the output stage
  assign forceOff = (|interlockHit) ||
    (|(conditions & outputOffMask));
  assign outputOnRequestValid = |onCtlSel;
  assign outputOnRequest = |onCtlHit;
  assign statusSummary = (|(conditions & conditionReportMask)) ||
    (|(eventLatch & eventReportMask));

  // Panel lockout; panel keys cannot touch the enable
  assign panelLocked = !frontPanelEnable;
  assign panelKeysGated = frontPanelEnable ? panelKeys : '0;

  // ----------------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------------
  assign queryInFunc = inFunc[queryPort];
  assign queryInInvert = inInvert[queryPort];
  assign queryOutFunc = outFunc[queryPort];
  assign queryOutInvert = outInvert[queryPort];
  assign queryInPinState = inSync[queryPort];
  assign queryOutPinState = outPin[queryPort];

  // ----------------------------------------------------------------------
  // Configuration next values
  // ----------------------------------------------------------------------
  always_comb begin
    next_inFunc = inFunc;
    next_inInvert = inInvert;
    next_outFunc = outFunc;
    next_outInvert = outInvert;
    next_frontPanelEnable = frontPanelEnable;
    next_auxLimitEnable = auxLimitEnable;
    next_conditionReportMask = conditionReportMask;
    next_eventReportMask = eventReportMask;
    next_outputOffMask = outputOffMask;
    unique case (cmdOp)
      dio_status_pkg::CMD_NONE: begin
      end
      dio_status_pkg::CMD_IN_MODE: begin
        next_inFunc[cmdPort] = cmdFunc[1:0];
        next_inInvert[cmdPort] = cmdInvert;
      end
      dio_status_pkg::CMD_OUT_MODE: begin
        // Relay invert is the host's duty to keep zero
        next_outFunc[cmdPort] = cmdFunc;
        next_outInvert[cmdPort] = cmdInvert;
      end
      dio_status_pkg::CMD_PANEL: begin
        next_frontPanelEnable = cmdData[0];
      end
      dio_status_pkg::CMD_AUX: begin
        next_auxLimitEnable = cmdData[0];
      end
      dio_status_pkg::CMD_COND_MASK: begin
        next_conditionReportMask = cmdData;
      end
      dio_status_pkg::CMD_EVENT_MASK: begin
        next_eventReportMask = cmdData;
      end
      dio_status_pkg::CMD_OFF_MASK: begin
        next_outputOffMask = cmdData;
      end
    endcase
    // New events win over the clear of a read in the same cycle
    next_eventLatch = (readEventLatch ? 16'h0000 : eventLatch) |
      eventIn;
  end

  // Registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_IN; i++) begin
        inFunc[i] <= `IN_FUNC_MONITOR;
      end
      for (int i = 0; i < NUM_OUT; i++) begin
        outFunc[i] <= `OUT_FUNC_LOW;
      end
      inInvert <= '0;
      outInvert <= '0;
      frontPanelEnable <= `FRONT_PANEL_RESET;
      auxLimitEnable <= 1'b0;
      conditionReportMask <= `MASK_RESET;
      eventReportMask <= `MASK_RESET;
      outputOffMask <= `MASK_RESET;
      eventLatch <= 16'h0000;
      outPin <= '0;
    end else begin
      inFunc <= next_inFunc;
      inInvert <= next_inInvert;
      outFunc <= next_outFunc;
      outInvert <= next_outInvert;
      frontPanelEnable <= next_frontPanelEnable;
      auxLimitEnable <= next_auxLimitEnable;
      conditionReportMask <= next_conditionReportMask;
      eventReportMask <= next_eventReportMask;
      outputOffMask <= next_outputOffMask;
      eventLatch <= next_eventLatch;
      outPin <= next_outPin;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence cmd_out_low_s;
    cmdOp == dio_status_pkg::CMD_OUT_MODE && cmdFunc == 3'h0;
  endsequence
  static_low_pin_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cmd_out_low_s ##1 1'b1 |=> !outPin[$past(cmdPort, 2)])
    else $error("static low output not low");
  panel_restore_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !frontPanelEnable && cmdOp != dio_status_pkg::CMD_PANEL
    |=> !frontPanelEnable)
    else $error("panel unlocked without host write");
  panel_keys_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    panelLocked |-> panelKeysGated == '0)
    else $error("keys pass while locked");
  event_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    readEventLatch && eventIn == 16'h0000 |=> eventLatch == 16'h0000)
    else $error("event latch not cleared by read");
  aux_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !auxLimitEnable |-> conditions == conditionIn)
    else $error("aux limit raised while disabled");
  interlock_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (|interlockHit) |-> forceOff)
    else $error("interlock did not force off");
  summary_mask_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    conditionReportMask == 16'h0000 && eventReportMask == 16'h0000
    |-> !statusSummary)
    else $error("summary set with masks clear");
  off_mask_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    outputOffMask == 16'h0000 && interlockHit == '0 |-> !forceOff)
    else $error("output forced off with empty mask");
  in_mode_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    cmdOp == dio_status_pkg::CMD_IN_MODE
    |=> queryInFunc == $past(cmdFunc[1:0]) ||
        queryPort != $past(cmdPort))
    else $error("input function readback wrong");

endmodule

// file: verilog/dio_status_consts.svh
`ifndef DIO_STATUS_CONSTS_SVH
`define DIO_STATUS_CONSTS_SVH

// ----------------------------------------------------------------------
// Input function codes
// ----------------------------------------------------------------------
`define IN_FUNC_MONITOR 2'h0
`define IN_FUNC_INTERLOCK 2'h1
`define IN_FUNC_OUTPUT_ON 2'h2

// ----------------------------------------------------------------------
// Output function codes
// ----------------------------------------------------------------------
`define OUT_FUNC_LOW 3'h0
`define OUT_FUNC_HIGH 3'h1
`define OUT_FUNC_OUTPUT_ON 3'h2
`define OUT_FUNC_TEMP_STABLE 3'h3
`define OUT_FUNC_TEMP_LIMIT 3'h4
`define OUT_FUNC_CURR_LIMIT 3'h5
`define OUT_FUNC_REMOTE 3'h6
`define OUT_FUNC_VOLT_LIMIT 3'h7

// ----------------------------------------------------------------------
// Condition bit positions and reset values
// ----------------------------------------------------------------------
`define COND_TEMP_HIGH_BIT 3
`define COND_TEMP_LOW_BIT 4
`define MASK_RESET 16'h0000
`define FRONT_PANEL_RESET 1'b1

`endif

// file: verilog/dio_status_pkg.sv
package dio_status_pkg;

  // Host command selecting which setting is written
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_IN_MODE,
    CMD_OUT_MODE,
    CMD_PANEL,
    CMD_AUX,
    CMD_COND_MASK,
    CMD_EVENT_MASK,
    CMD_OFF_MASK
  } cmd_type;

endpackage

// file: verilog/port_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for a bus of asynchronous pins
module port_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Data
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta; // First stage, read only by the second
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_synced;

  // ----------------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------------
  always_comb begin
    next_meta = async;
    next_synced = meta;
  end

  // Registers, cleared on reset
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      meta <= '0;
      synced <= '0;
    end else begin
      meta <= next_meta;
      synced <= next_synced;
    end
  end

endmodule

// file: verification/far_side_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Switches and interlock loops wired to the input pins
// ------------------------------------------------------------
module far_side_model (
  // Clock
  input wire logic sys_clk,
  // Contact levels wanted by the bench
  input wire logic [3:0] level,
  // Pins
  output logic [3:0] inPin
);
  // Contacts move away from the sampling edge, so the block's
  // synchroniser is the only thing deciding when a change lands
  initial inPin = 4'h0;
  always @(negedge sys_clk) begin
    inPin <= level;
  end
endmodule

// file: verification/digital_io_status_tb.sv
`timescale 1ns/100ps
module digital_io_status_tb;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  dio_status_pkg::cmd_type cmdOp = dio_status_pkg::CMD_NONE;
  logic [1:0] cmdPort = 2'h0, queryPort = 2'h0;
  logic [2:0] cmdFunc = 3'h0;
  logic cmdInvert = 1'b0, readEventLatch = 1'b0;
  logic [15:0] cmdData = 16'h0, conditionIn = 16'h0, eventIn = 16'h0;
  logic outputOnState = 1'b1, tempStable = 1'b0, tempLimit = 1'b1;
  logic currentLimit = 1'b0, remoteMode = 1'b1, voltageLimit = 1'b0;
  logic auxAboveHigh = 1'b0, auxBelowLow = 1'b0;
  logic [3:0] panelKeys = 4'hf, level = 4'h0, inPin, outPin;
  logic [1:0] queryInFunc;
  logic [2:0] queryOutFunc;
  logic queryInInvert, queryOutInvert, queryInPinState, queryOutPinState;
  logic frontPanelEnable, auxLimitEnable, panelLocked, forceOff;
  logic outputOnRequest, outputOnRequestValid, statusSummary;
  logic [15:0] eventLatch, conditionReportMask, eventReportMask;
  logic [15:0] outputOffMask, conditions;
  logic [3:0] panelKeysGated;
  int badCount = 0; // Mismatches seen
  int totalChecks = 0; // Comparisons made

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  digital_io_status digital_io_status_i (
    .sys_clk, .nrst, .cmdOp, .cmdPort, .cmdFunc, .cmdInvert, .cmdData,
    .queryPort, .readEventLatch, .queryInFunc, .queryInInvert,
    .queryOutFunc, .queryOutInvert, .queryInPinState, .queryOutPinState,
    .eventLatch, .frontPanelEnable, .auxLimitEnable, .conditionReportMask,
    .eventReportMask, .outputOffMask, .inPin, .outPin, .conditionIn,
    .eventIn, .outputOnState, .tempStable, .tempLimit, .currentLimit,
    .remoteMode, .voltageLimit, .auxAboveHigh, .auxBelowLow, .panelKeys,
    .panelLocked, .panelKeysGated, .conditions, .forceOff,
    .outputOnRequest, .outputOnRequestValid, .statusSummary
  );
  far_side_model far_side_model_i (.sys_clk, .level, .inPin);

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One command per pulse; the register is visible on return
  task automatic cmd(input dio_status_pkg::cmd_type op, input logic [1:0] p,
                     input logic [2:0] f, input logic inv,
                     input logic [15:0] d);
    @(negedge sys_clk);
    cmdOp = op; cmdPort = p; cmdFunc = f; cmdInvert = inv; cmdData = d;
    @(negedge sys_clk);
    cmdOp = dio_status_pkg::CMD_NONE;
  endtask

  // Contacts need two synchroniser stages plus margin
  task automatic pins(input logic [3:0] v);
    level = v;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic do_reset;
    @(negedge sys_clk);
    nrst = 1'b0;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
  endtask

  task automatic finalReport;
    $display("Checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset;
    check("panel", frontPanelEnable, 16'h1);
    check("aux", auxLimitEnable, 16'h0);
    check("cmask", conditionReportMask, 16'h0);
    check("emask", eventReportMask, 16'h0);
    check("offmask", outputOffMask, 16'h0);
    check("outfunc", queryOutFunc, 16'h0);
    check("outpin", outPin, 16'h0);
    check("latch0", eventLatch, 16'h0);
    $display("test reset done");
  endtask

  // Every output code, both polarities, on a plain pin
  task automatic test_out_func;
    logic [7:0] src;
    logic e;
    src = 8'h56; // Active state of each source as driven above
    queryPort = 2'h1;
    for (int inv = 0; inv < 2; inv++) begin
      for (int c = 0; c < 8; c++) begin
        cmd(dio_status_pkg::CMD_OUT_MODE, 2'h1, c[2:0], inv[0], 16'h0);
        repeat (2) @(negedge sys_clk);
        e = (c < 2) ? c[0] : src[c] ^ inv[0];
        check("qfunc", queryOutFunc, c[2:0]);
        check("qinv", queryOutInvert, inv[0]);
        check("pin", outPin[1], e);
        check("pinstate", queryOutPinState, e);
      end
    end
    // Relay closed statically, polarity kept at zero
    cmd(dio_status_pkg::CMD_OUT_MODE, 2'h0, 3'h1, 1'b0, 16'h0);
    queryPort = 2'h0;
    repeat (2) @(negedge sys_clk);
    check("relay", queryOutPinState, 16'h1);
    $display("test output functions done");
  endtask

  task automatic test_inputs;
    queryPort = 2'h2;
    cmd(dio_status_pkg::CMD_IN_MODE, 2'h2, 3'h1, 1'b1, 16'h0);
    check("qinfunc", queryInFunc, 16'h1);
    check("qininv", queryInInvert, 16'h1);
    pins(4'h4);
    check("offhigh", forceOff, 16'h0);
    check("instate", queryInPinState, 16'h1);
    pins(4'h0);
    check("offlow", forceOff, 16'h1);
    check("instate0", queryInPinState, 16'h0);
    cmd(dio_status_pkg::CMD_IN_MODE, 2'h2, 3'h2, 1'b0, 16'h0);
    check("onvalid", outputOnRequestValid, 16'h1);
    check("onreq0", outputOnRequest, 16'h0);
    check("offmon", forceOff, 16'h0);
    pins(4'h4);
    check("onreq1", outputOnRequest, 16'h1);
    cmd(dio_status_pkg::CMD_IN_MODE, 2'h2, 3'h0, 1'b0, 16'h0);
    check("monvalid", outputOnRequestValid, 16'h0);
    $display("test inputs done");
  endtask

  task automatic test_panel;
    cmd(dio_status_pkg::CMD_PANEL, 2'h0, 3'h0, 1'b0, 16'h0);
    check("locked", panelLocked, 16'h1);
    check("panelrd", frontPanelEnable, 16'h0);
    check("keys", panelKeysGated, 16'h0);
    panelKeys = 4'h5;
    repeat (3) @(negedge sys_clk);
    check("stays", panelLocked, 16'h1);
    cmd(dio_status_pkg::CMD_PANEL, 2'h0, 3'h0, 1'b0, 16'h1);
    check("unlock", panelLocked, 16'h0);
    check("keys5", panelKeysGated, 16'h5);
    cmd(dio_status_pkg::CMD_PANEL, 2'h0, 3'h0, 1'b0, 16'h0);
    $display("test panel done");
  endtask

  task automatic test_aux;
    auxAboveHigh = 1'b1;
    @(negedge sys_clk);
    check("auxoff", conditions, 16'h0);
    cmd(dio_status_pkg::CMD_AUX, 2'h0, 3'h0, 1'b0, 16'h1);
    check("auxhi", conditions, 16'h0008);
    check("auxrd", auxLimitEnable, 16'h1);
    check("nomask", forceOff, 16'h0);
    cmd(dio_status_pkg::CMD_OFF_MASK, 2'h0, 3'h0, 1'b0, 16'h0008);
    check("masked", forceOff, 16'h1);
    check("offrd", outputOffMask, 16'h0008);
    auxAboveHigh = 1'b0;
    auxBelowLow = 1'b1;
    @(negedge sys_clk);
    check("auxlo", conditions, 16'h0010);
    check("lonomask", forceOff, 16'h0);
    auxBelowLow = 1'b0;
    $display("test aux limits done");
  endtask

  task automatic test_status;
    conditionIn = 16'h0201;
    @(negedge sys_clk);
    check("sum0", statusSummary, 16'h0);
    cmd(dio_status_pkg::CMD_COND_MASK, 2'h0, 3'h0, 1'b0, 16'h0200);
    check("cmaskrd", conditionReportMask, 16'h0200);
    check("sumc", statusSummary, 16'h1);
    cmd(dio_status_pkg::CMD_COND_MASK, 2'h0, 3'h0, 1'b0, 16'h0100);
    check("sumc0", statusSummary, 16'h0);
    conditionIn = 16'h0;
    eventIn = 16'h0400;
    @(negedge sys_clk);
    eventIn = 16'h0;
    @(negedge sys_clk);
    check("latch", eventLatch, 16'h0400);
    check("sume0", statusSummary, 16'h0);
    cmd(dio_status_pkg::CMD_EVENT_MASK, 2'h0, 3'h0, 1'b0, 16'h0400);
    check("emaskrd", eventReportMask, 16'h0400);
    check("sume", statusSummary, 16'h1);
    readEventLatch = 1'b1;
    @(negedge sys_clk);
    readEventLatch = 1'b0;
    check("cleared", eventLatch, 16'h0);
    check("sumclr", statusSummary, 16'h0);
    $display("test status masks done");
  endtask

  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    do_reset();
    test_reset();
    test_out_func();
    test_inputs();
    test_panel();
    test_aux();
    test_status();
    // Second reset in mid-run brings the panel back
    do_reset();
    test_reset();
    finalReport();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    badCount++;
    finalReport();
  end
endmodule
